// [eelc_defs.svh]
// Register offsets, reset values and field positions of the line block
`ifndef EELC_DEFS_SVH
`define EELC_DEFS_SVH

// Number of trigger lines
`define EELC_LINES 10
// Lines 0..7 come from port pins
`define EELC_PIN_LINES 8
// Supply monitor line index
`define EELC_SUPPLY_LINE 8
// Auto wake-up line index
`define EELC_WAKE_LINE 9

// Register byte offsets
`define EELC_OFF_IRQ_EN 8'h00
`define EELC_OFF_EVT_EN 8'h04
`define EELC_OFF_RISE 8'h08
`define EELC_OFF_FALL 8'h0c
`define EELC_OFF_SOFT 8'h10
`define EELC_OFF_PEND 8'h14
`define EELC_OFF_PORT_SEL 8'h18

// Reset values
`define EELC_RST_MASK 10'h000
`define EELC_RST_PORT_SEL 16'h0000

// Port select field: two bits per pin line
`define EELC_PORT_SEL_W 2

// Core vector numbers served by this block
`define EELC_VEC_SHARED 8'h14
`define EELC_VEC_SUPPLY 8'h11

`endif

// [eelc_pkg.sv]
// Types shared by the external event line controller
package eelc_pkg;
  // One bit per line
  typedef logic [9:0] eelc_mask_t;
  // Port feeding a pin line
  typedef enum logic [1:0] {
    EELC_PORT_A,
    EELC_PORT_C,
    EELC_PORT_D,
    EELC_PORT_NONE
  } eelc_port_t;
endpackage

// [external_event_line_controller.sv]
// Ten-line external interrupt and event controller with register port
// Overview of operation
// R1: Software bit or external input raises line
// R2: External input counts only on detected edge
// R3: Edge trigger ORed with software trigger
// R4: Separate interrupt and event enable gates
// R5: Interrupt and event produced independently
// R6: Configured edge sets pending, raises request
// R7: Write one clears pending, zero keeps
// R8: Rising and falling selects, both allowed
// R9: Software bit with enable gives interrupt
// R10: Six registers readable and writable by processor
// R11: Wake-up event releases core from sleep
// R12: Pending on core-masked line wakes if enabled
// R13: Core clears pending flags after pending wake
// R14: Event wake leaves no state to clear
// R15: Lines 0-7 share core vector 20
// R16: Supply line uses own vector 17
// R17: Pin lines take pin from selected port
// R18: Line 8 supply monitor, 9 wake-up
// R19: Four ten-bit fields, reset zero
// R20: Consecutive samples differing give one-cycle pulse
// R21: Request holds while pending and enabled
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "eelc_defs.svh"
`default_nettype none

module external_event_line_controller (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portCPins,
  input wire logic [7:0] portDPins,
  input wire logic supplyMonitorOut,
  input wire logic autoWakeupEvent,
  input wire logic coreSharedVecEnable,
  input wire logic coreSupplyVecEnable,
  input wire logic sendEventOnPending,
  output logic sharedPinLineIrq,
  output logic supplyMonitorIrq,
  output logic [9:0] lineEvent,
  output logic wakeupEvent
);

  // Pin samples, port pins plus supply monitor
  localparam int SyncW = 25;

  // All checks below run on the one clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pick the pin of one line from its selected port
  function automatic logic pickPin(
    input logic [1:0] sel,
    input logic [7:0] a,
    input logic [7:0] c,
    input logic [7:0] d,
    input int idx
  );
    logic pin;
    pin = 1'b0;
    case (eelc_pkg::eelc_port_t'(sel))
      eelc_pkg::EELC_PORT_A: pin = a[idx];
      eelc_pkg::EELC_PORT_C: pin = c[idx];
      eelc_pkg::EELC_PORT_D: pin = d[idx];
      default: pin = 1'b0; // Reserved code reads low
    endcase
    return pin;
  endfunction

  // Register file
  eelc_pkg::eelc_mask_t irqEnable_ff; // Interrupt enable per line
  eelc_pkg::eelc_mask_t eventEnable_ff; // Event enable per line
  eelc_pkg::eelc_mask_t riseSelect_ff; // Rising edge select
  eelc_pkg::eelc_mask_t fallSelect_ff; // Falling edge select
  eelc_pkg::eelc_mask_t softTrigger_ff; // Software trigger bits
  eelc_pkg::eelc_mask_t pending_ff; // Interrupt pending flags
  logic [15:0] portSelect_ff; // Port choice of lines 0..7

  // Input synchronisers and edge history
  logic [SyncW-1:0] syncA_ff; // First stage, read by syncB only
  logic [SyncW-1:0] syncB_ff; // Second stage
  eelc_pkg::eelc_mask_t linePrev_ff; // Previous line sample

  // Next values
  eelc_pkg::eelc_mask_t nxt_irqEnable;
  eelc_pkg::eelc_mask_t nxt_eventEnable;
  eelc_pkg::eelc_mask_t nxt_riseSelect;
  eelc_pkg::eelc_mask_t nxt_fallSelect;
  eelc_pkg::eelc_mask_t nxt_softTrigger;
  eelc_pkg::eelc_mask_t nxt_pending;
  logic [15:0] nxt_portSelect;
  logic [31:0] nxt_regRdData;

  // Address decode
  wire logic hitIrqEn = regAddr == `EELC_OFF_IRQ_EN;
  wire logic hitEvtEn = regAddr == `EELC_OFF_EVT_EN;
  wire logic hitRise = regAddr == `EELC_OFF_RISE;
  wire logic hitFall = regAddr == `EELC_OFF_FALL;
  wire logic hitSoft = regAddr == `EELC_OFF_SOFT;
  wire logic hitPend = regAddr == `EELC_OFF_PEND;
  wire logic hitPortSel = regAddr == `EELC_OFF_PORT_SEL;

  // Write data as a line mask, upper bits dropped
  wire eelc_pkg::eelc_mask_t wrMask = regWrData[9:0];
  wire logic wrSoft = regWrite && hitSoft;
  wire logic wrPend = regWrite && hitPend;

  // Line sources
  wire logic [7:0] syncPortA = syncB_ff[7:0];
  wire logic [7:0] syncPortC = syncB_ff[15:8];
  wire logic [7:0] syncPortD = syncB_ff[23:16];
  wire logic syncSupply = syncB_ff[24];
  eelc_pkg::eelc_mask_t lineNow;

  // Pin lines follow their port select
  always_comb begin
    lineNow = '0;
    for (int i = 0; i < `EELC_PIN_LINES; i++) begin
      lineNow[i] = pickPin(portSelect_ff[2*i +: `EELC_PORT_SEL_W],
        syncPortA, syncPortC, syncPortD, i); // R17
    end
    lineNow[`EELC_SUPPLY_LINE] = syncSupply; // R18
    // Wake-up unit is on this clock, so no synchroniser
    lineNow[`EELC_WAKE_LINE] = autoWakeupEvent; // R18
  end

  // Edge detection; level never triggers
  wire eelc_pkg::eelc_mask_t riseSeen =
    lineNow & ~linePrev_ff & riseSelect_ff; // R2 R8 R20
  wire eelc_pkg::eelc_mask_t fallSeen =
    ~lineNow & linePrev_ff & fallSelect_ff; // R2 R8 R20
  wire eelc_pkg::eelc_mask_t edgeTrig = riseSeen | fallSeen; // R8

  // Software trigger fires when a bit goes from 0 to 1
  wire eelc_pkg::eelc_mask_t softTrig =
    wrSoft ? (wrMask & ~softTrigger_ff) : '0; // R1 R9

  // Combined trigger feeds both gates
  wire eelc_pkg::eelc_mask_t lineTrig = edgeTrig | softTrig; // R1 R3

  // Two independent gates per line
  wire eelc_pkg::eelc_mask_t irqGate = lineTrig & irqEnable_ff; // R4 R5
  wire eelc_pkg::eelc_mask_t evtGate = lineTrig & eventEnable_ff; // R4 R5

  // Flags cleared by this write, write 0 keeps
  wire eelc_pkg::eelc_mask_t pendClear = wrPend ? wrMask : '0; // R7

  // Request level per line
  wire eelc_pkg::eelc_mask_t lineReq = pending_ff & irqEnable_ff; // R21

  // Lines whose core vector is masked; line 9 is not routed here
  wire eelc_pkg::eelc_mask_t coreMasked = {1'b0, ~coreSupplyVecEnable,
    {8{~coreSharedVecEnable}}};

  // Fresh pending on a core-masked line wakes the core
  wire logic pendWake =
    sendEventOnPending && |(irqGate & coreMasked); // R12

  // Register next values
  always_comb begin
    nxt_irqEnable = irqEnable_ff;
    nxt_eventEnable = eventEnable_ff;
    nxt_riseSelect = riseSelect_ff;
    nxt_fallSelect = fallSelect_ff;
    nxt_portSelect = portSelect_ff;
    if (regWrite) begin
      if (hitIrqEn) begin
        nxt_irqEnable = wrMask; // R10 R19
      end
      if (hitEvtEn) begin
        nxt_eventEnable = wrMask; // R10 R19
      end
      if (hitRise) begin
        nxt_riseSelect = wrMask; // R10 R19
      end
      if (hitFall) begin
        nxt_fallSelect = wrMask; // R10 R19
      end
      if (hitPortSel) begin
        nxt_portSelect = regWrData[15:0];
      end
    end
  end

  // Soft bits are set by writes, dropped with their pending flag;
  // a new set wins over a clear in the same cycle
  always_comb begin
    nxt_softTrigger = (softTrigger_ff & ~pendClear) | softTrig;
  end

  // Set wins over write-one clear
  always_comb begin
    nxt_pending = (pending_ff & ~pendClear) | irqGate; // R6 R7
  end

  // Read mux; unmapped offsets read zero, bits above 9 read zero except port select bits 15:10
  always_comb begin
    nxt_regRdData = '0;
    if (regRead) begin
      if (hitIrqEn) begin
        nxt_regRdData[9:0] = irqEnable_ff; // R10
      end else if (hitEvtEn) begin
        nxt_regRdData[9:0] = eventEnable_ff;
      end else if (hitRise) begin
        nxt_regRdData[9:0] = riseSelect_ff;
      end else if (hitFall) begin
        nxt_regRdData[9:0] = fallSelect_ff;
      end else if (hitSoft) begin
        nxt_regRdData[9:0] = softTrigger_ff;
      end else if (hitPend) begin
        nxt_regRdData[9:0] = pending_ff;
      end else if (hitPortSel) begin
        nxt_regRdData[15:0] = portSelect_ff;
      end
    end
  end

  // Two-stage synchroniser for pins and the supply monitor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {supplyMonitorOut, portDPins, portCPins, portAPins};
      syncB_ff <= syncA_ff;
    end
  end

  // Edge history; a port select change may look like one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linePrev_ff <= '0;
    end else begin
      linePrev_ff <= lineNow; // R20
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnable_ff <= `EELC_RST_MASK; // R19
      eventEnable_ff <= `EELC_RST_MASK;
      riseSelect_ff <= `EELC_RST_MASK;
      fallSelect_ff <= `EELC_RST_MASK;
      portSelect_ff <= `EELC_RST_PORT_SEL;
    end else begin
      irqEnable_ff <= nxt_irqEnable;
      eventEnable_ff <= nxt_eventEnable;
      riseSelect_ff <= nxt_riseSelect;
      fallSelect_ff <= nxt_fallSelect;
      portSelect_ff <= nxt_portSelect;
    end
  end

  // Trigger and flag state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      softTrigger_ff <= `EELC_RST_MASK;
      pending_ff <= `EELC_RST_MASK;
    end else begin
      softTrigger_ff <= nxt_softTrigger;
      pending_ff <= nxt_pending; // R6
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
      sharedPinLineIrq <= 1'b0;
      supplyMonitorIrq <= 1'b0;
      lineEvent <= '0;
      wakeupEvent <= 1'b0;
    end else begin
      regRdData <= nxt_regRdData; // R10
      sharedPinLineIrq <= |lineReq[`EELC_PIN_LINES-1:0]; // R15 R21
      supplyMonitorIrq <= lineReq[`EELC_SUPPLY_LINE]; // R16 R21
      // Events are pulses and leave no flag behind
      lineEvent <= evtGate; // R5 R14
      wakeupEvent <= (|evtGate) || pendWake; // R11 R12 R14
    end
  end

  // Checks
  pend_set_a: assert property ( // R6
    (irqGate != '0) |=> ((pending_ff & $past(irqGate)) == $past(irqGate)))
    else $error("pending flag not set by trigger");

  w1c_clear_a: assert property ( // R7
    (wrPend && irqGate == '0) |=> (pending_ff == $past(pending_ff & ~wrMask)))
    else $error("write one clear wrong");

  both_edge_a: assert property ( // R8
    (((lineNow ^ linePrev_ff) & riseSelect_ff & fallSelect_ff & irqEnable_ff)
      != '0) |=> (pending_ff != '0))
    else $error("double edge did not set pending");

  soft_irq_a: assert property ( // R9
    (wrSoft && ((wrMask & ~softTrigger_ff & irqEnable_ff) != '0))
      |=> (pending_ff != '0) ##1 (lineReq != '0))
    else $error("software trigger gave no interrupt");

  read_back_a: assert property ( // R10
    (regRead && hitIrqEn) |=> (regRdData[9:0] == $past(irqEnable_ff)
      && regRdData[31:10] == '0))
    else $error("enable read back wrong");

  read_idle_a: assert property ( // R10
    !regRead |=> (regRdData == '0))
    else $error("read data outside read slot");

  event_wake_a: assert property ( // R11
    (evtGate != '0) |=> (wakeupEvent && lineEvent == $past(evtGate)))
    else $error("event did not wake core");

  pend_wake_a: assert property ( // R12
    (sendEventOnPending && irqGate[`EELC_SUPPLY_LINE]
      && !coreSupplyVecEnable) |=> wakeupEvent)
    else $error("pending on masked vector did not wake");

  event_pulse_a: assert property ( // R14
    (eventEnable_ff != '0 && irqEnable_ff == '0 && lineTrig != '0
      && !wrPend) |=> $stable(pending_ff))
    else $error("event path left state behind");

  shared_vec_a: assert property ( // R15
    sharedPinLineIrq == $past(|lineReq[`EELC_PIN_LINES-1:0]))
    else $error("shared vector request wrong");

  supply_vec_a: assert property ( // R16
    (lineReq[`EELC_SUPPLY_LINE] && !wrPend && !(regWrite && hitIrqEn))
      |=> ##1 supplyMonitorIrq)
    else $error("supply vector request missing");

  // Main scenarios
  soft_irq_c: cover property (wrSoft ##1 sharedPinLineIrq);
  both_edge_c: cover property (
    (riseSeen != '0) ##[1:20] (fallSeen != '0));
  pend_wake_c: cover property (pendWake ##1 wakeupEvent);
  clear_c: cover property (sharedPinLineIrq ##1 wrPend ##2 !sharedPinLineIrq);

endmodule

`default_nettype wire

// [eelc_core_model.sv]
// Behavioural model of the core's sleep and wake handling
`timescale 1ns/1ps
`default_nettype none

module eelc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enterSleep,
  input wire logic wakeupEvent,
  output logic asleep
);
  // Sleep flag: a wait-for-event sleep left only on a wake pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else if (wakeupEvent) begin
      asleep <= 1'b0;
    end else if (enterSleep) begin
      asleep <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// [external_event_line_controller_tb.sv]
// Self-checking bench for the external event line controller
`timescale 1ns/1ps
`include "eelc_defs.svh"
`default_nettype none

module external_event_line_controller_tb;
  logic clk = 1'b0; // Bench clock, driven by its own always block only
  logic rst_n, regWrite, regRead, enterSleep, asleep;
  logic [7:0] regAddr, portAPins, portCPins, portDPins;
  logic [31:0] regWrData, regRdData;
  logic supplyMonitorOut, autoWakeupEvent, sendEventOnPending;
  logic coreSharedVecEnable, coreSupplyVecEnable;
  logic sharedPinLineIrq, supplyMonitorIrq, wakeupEvent;
  logic [9:0] lineEvent;
  logic [31:0] evCnt [10] = '{default: 32'h0}; // Event pulses per line
  logic [31:0] wakeCnt = 32'h0; // Wake pulses seen
  logic [31:0] base;
  int n_fail, checked;

  external_event_line_controller u_external_event_line_controller (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .portAPins(portAPins), .portCPins(portCPins), .portDPins(portDPins),
    .supplyMonitorOut(supplyMonitorOut), .autoWakeupEvent(autoWakeupEvent),
    .coreSharedVecEnable(coreSharedVecEnable),
    .coreSupplyVecEnable(coreSupplyVecEnable),
    .sendEventOnPending(sendEventOnPending),
    .sharedPinLineIrq(sharedPinLineIrq), .supplyMonitorIrq(supplyMonitorIrq),
    .lineEvent(lineEvent), .wakeupEvent(wakeupEvent));

  eelc_core_model u_eelc_core_model (.clk(clk), .rst_n(rst_n),
    .enterSleep(enterSleep), .wakeupEvent(wakeupEvent), .asleep(asleep));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Pulse counters; outputs are one-cycle pulses, so one count each
  always @(posedge clk) begin
    for (int i = 0; i < 10; i++) begin
      if (lineEvent[i] === 1'b1) evCnt[i] <= evCnt[i] + 32'h1;
    end
    if (wakeupEvent === 1'b1) wakeCnt <= wakeCnt + 32'h1;
  end

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Single compare; four-state match only
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read strobe, data taken in the following cycle only
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(nm, e, regRdData);
  endtask

  // Pulses on one line over eight cycles after a stimulus
  task automatic cnt(input int ln, input logic [31:0] e, input string nm);
    base = evCnt[ln];
    repeat (8) @(posedge clk);
    chk(nm, e, evCnt[ln] - base);
  endtask

  task automatic sleep;
    @(posedge clk);
    enterSleep <= 1'b1;
    @(posedge clk);
    enterSleep <= 1'b0;
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_n = 0; regWrite = 0; regRead = 0; regAddr = 8'h00;
    regWrData = 32'h0; portAPins = 8'h00; portCPins = 8'h00;
    portDPins = 8'h00; supplyMonitorOut = 0; autoWakeupEvent = 0;
    coreSharedVecEnable = 1; coreSupplyVecEnable = 1;
    sendEventOnPending = 0; enterSleep = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then reserved bits dropped on readback
    for (int o = 0; o < 8'h1c; o += 4) rdchk(8'(o), 32'h0, "reset");
    rdchk(8'h1c, 32'h0, "unmapped");
    for (int o = 0; o < 8'h10; o += 4) begin
      wr(8'(o), 32'hffffffff);
      rdchk(8'(o), 32'h000003ff, "rw mask");
      wr(8'(o), 32'h0);
    end
    wr(`EELC_OFF_PORT_SEL, 32'hffffffff);
    rdchk(`EELC_OFF_PORT_SEL, 32'h0000ffff, "port sel");
    wr(`EELC_OFF_PORT_SEL, 32'h0);
    // Software trigger into interrupt only
    wr(`EELC_OFF_IRQ_EN, 32'h3ff);
    wr(`EELC_OFF_SOFT, 32'h1);
    #1 chk("no event", 32'h0, {22'h0, lineEvent});
    @(posedge clk);
    #1 chk("shared irq", 32'h1, {31'h0, sharedPinLineIrq});
    rdchk(`EELC_OFF_PEND, 32'h1, "pend set");
    wr(`EELC_OFF_PEND, 32'h0);
    rdchk(`EELC_OFF_PEND, 32'h1, "pend w0");
    chk("irq holds", 32'h1, {31'h0, sharedPinLineIrq});
    wr(`EELC_OFF_PEND, 32'h1);
    rdchk(`EELC_OFF_PEND, 32'h0, "pend w1");
    chk("irq drop", 32'h0, {31'h0, sharedPinLineIrq});
    // Supply line goes to its own vector
    wr(`EELC_OFF_SOFT, 32'h100);
    repeat (2) @(posedge clk);
    #1 chk("supply irq", 32'h1, {31'h0, supplyMonitorIrq});
    chk("not shared", 32'h0, {31'h0, sharedPinLineIrq});
    wr(`EELC_OFF_PEND, 32'h3ff);
    // Event only: a pulse that leaves no flag behind
    wr(`EELC_OFF_IRQ_EN, 32'h0);
    wr(`EELC_OFF_EVT_EN, 32'h3ff);
    sleep();
    #1 chk("asleep", 32'h1, {31'h0, asleep});
    wr(`EELC_OFF_SOFT, 32'h200);
    #1 chk("event", 32'h200, {22'h0, lineEvent});
    chk("wake", 32'h1, {31'h0, wakeupEvent});
    @(posedge clk);
    #1 chk("event pulse", 32'h0, {22'h0, lineEvent});
    chk("awake", 32'h0, {31'h0, asleep});
    rdchk(`EELC_OFF_PEND, 32'h0, "no flag");
    wr(`EELC_OFF_PEND, 32'h3ff);
    // Edge selection on line 0, pin held as a level
    wr(`EELC_OFF_IRQ_EN, 32'h3ff);
    for (int m = 1; m < 4; m++) begin
      wr(`EELC_OFF_RISE, {31'h0, m[0]});
      wr(`EELC_OFF_FALL, {31'h0, m[1]});
      portAPins[0] <= 1'b1;
      cnt(0, {31'h0, m[0]}, "rise edge");
      wr(`EELC_OFF_PEND, 32'h3ff);
      portAPins[0] <= 1'b0;
      cnt(0, {31'h0, m[1]}, "fall edge");
      wr(`EELC_OFF_PEND, 32'h3ff);
    end
    // Line 3 taken from port C only
    wr(`EELC_OFF_RISE, 32'h3ff);
    wr(`EELC_OFF_FALL, 32'h0);
    wr(`EELC_OFF_PORT_SEL, 32'h40);
    repeat (4) @(posedge clk);
    wr(`EELC_OFF_PEND, 32'h3ff);
    portAPins[3] <= 1'b1;
    cnt(3, 32'h0, "port A off");
    portCPins[3] <= 1'b1;
    cnt(3, 32'h1, "port C");
    // Line 3 moved over to port D
    wr(`EELC_OFF_PORT_SEL, 32'h80);
    portDPins[3] <= 1'b1;
    cnt(3, 32'h1, "port D");
    wr(`EELC_OFF_PEND, 32'h3ff);
    // Internal sources on lines 8 and 9
    supplyMonitorOut <= 1'b1;
    cnt(8, 32'h1, "supply line");
    autoWakeupEvent <= 1'b1;
    cnt(9, 32'h1, "wake line");
    rdchk(`EELC_OFF_PEND, 32'h300, "pend 8 9");
    wr(`EELC_OFF_PEND, 32'h3ff);
    // Pending wake with the vector masked in the core
    wr(`EELC_OFF_EVT_EN, 32'h0);
    coreSharedVecEnable <= 1'b0;
    coreSupplyVecEnable <= 1'b0;
    sendEventOnPending <= 1'b1;
    sleep();
    #1 chk("asleep", 32'h1, {31'h0, asleep});
    // Shared and supply lines both masked in the core
    wr(`EELC_OFF_SOFT, 32'h101);
    repeat (3) @(posedge clk);
    #1 chk("pend wake", 32'h0, {31'h0, asleep});
    wr(`EELC_OFF_PEND, 32'h101);
    sendEventOnPending <= 1'b0;
    sleep();
    base = wakeCnt;
    wr(`EELC_OFF_SOFT, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk("no sev wake", 32'h0, wakeCnt - base);
    chk("still asleep", 32'h1, {31'h0, asleep});
    print_verdict();
  end
endmodule

`default_nettype wire
